// ---- mab_pkg.sv ----
// Package of constants and carrier types for the multiplexed address/data bus interface.
// What this block does
// - Each transaction runs an address phase then a data phase on shared lines.
// - Address phase drives upper address bits on shared lines 31 down to 4.
// - Address phase drives four active-low byte strobes on shared lines 3 to 0.
// - Byte strobes matter only for 32-bit ports; otherwise value is insignificant.
// - With the coprocessor bit set, strobes stay inactive on reads.
// - Write data phase drives store data taken from the write buffer.
// - Reads return one datum or four words; words go to the read buffer.
// - Byte lanes follow datum size, port width and byte ordering.
// - Low address bits valid per port width: 3:2, 3:1 or 3:0.
// - Writes and single reads show exact address, then increment if datum is wider.
// - Burst reads count low address from zero in steps of port width.
// - During reset the low address pins are configuration inputs.
// - Diagnostic pin in read address phase is high for cache miss.
// - Diagnostic pin in read data slot is high for instruction reference.
// - Address strobe is high for the first cycle in which shared lines hold a valid address.
// - Drive-release output rises once the device stops driving shared lines.
package mab_pkg;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {PW_32, PW_16, PW_8} mab_width_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_TRI, SZ_WORD} mab_size_t;

  localparam int unsigned BURST_WORDS = 4;
  localparam logic [3:0]  STROBES_OFF = 4'hF;
  localparam logic [1:0]  CFG_BYTE_BIT = 2'h0;
  localparam logic [1:0]  CFG_RSV_BIT  = 2'h1;
  localparam logic [1:0]  CFG_HALF_BIT = 2'h2;
  localparam logic [1:0]  CFG_HOLD_BIT = 2'h3;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [31:0] addr;
    mab_size_t   size;
    mab_width_t  width;
    logic        write;
    logic        burst;
    logic        cacheMiss;
    logic        instrRef;
    logic [31:0] wdata;
  } mab_req_t;

  typedef struct packed {
    logic bootRomByteWide;
    logic reservedConfigHigh;
    logic bootRomHalfWide;
    logic extendedAddressHold;
  } mab_cfg_t;

endpackage

// ---- mab_lane_reg.sv ----
// Small register memory that holds the four words of a read burst on a 32-bit port.
`timescale 1ns/1ps
module mab_lane_reg
  import mab_pkg::*;
#(
  parameter int unsigned DEPTH = 4
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrIdx,
  input  wire logic [31:0]              wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdIdx,
  output logic      [31:0]              rdData
);
  logic [31:0] mem_reg [DEPTH];
  logic [31:0] rdData_reg;

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem_reg[wrIdx] <= wrData;
    end
    if (rst) begin
      rdData_reg <= 32'h0000_0000;
    end else begin
      rdData_reg <= mem_reg[rdIdx];
    end
  end

  assign rdData = rdData_reg;
endmodule

// ---- mab_bus_if.sv ----
// Multiplexed address/data bus engine with low address counter and reset strap capture.
`timescale 1ns/1ps
module mab_bus_if
  import mab_pkg::*;
#(
  parameter int unsigned BURST_LEN = BURST_WORDS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire mab_req_t    req,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        bigEndian,
  input  wire logic        readStrobesOff,
  input  wire logic        dataReady,
  input  wire logic [31:0] adIn,
  output logic      [31:0] adOut,
  output logic             adOe,
  input  wire logic [3:0]  lowAddrIn,
  output logic      [3:0]  lowAddrOut,
  output logic             lowAddrOe,
  output logic             diag,
  output logic             addrLatchEnable,
  output logic             drive_release_signal,
  output mab_cfg_t         resetConfig,
  output logic      [31:0] readWord,
  output logic             readWordValid,
  input  wire logic [1:0]  readIdx,
  output logic      [31:0] readBufData,
  output logic             done
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [3:0] stepOf(input mab_width_t w);
    unique case (w)
      PW_32:   stepOf = 4'h4;
      PW_16:   stepOf = 4'h2;
      default: stepOf = 4'h1;
    endcase
  endfunction

  function automatic logic [3:0] bytesOf(input mab_size_t s);
    bytesOf = {2'b00, s} + 4'h1;
  endfunction

  function automatic logic [3:0] lanesOf(input logic [1:0] a, input mab_size_t s, input logic be);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (i >= a && i < a + bytesOf(s)) begin
        m[i] = 1'b1;
      end
    end
    lanesOf = be ? {m[0], m[1], m[2], m[3]} : m;
  endfunction

  // ****************************************************************
  // Reset configuration capture
  // ****************************************************************
  logic [3:0] strapS1_reg, strapS2_reg, strapS3_reg;
  mab_cfg_t   cfg_reg, cfg_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (rst && strapS2_reg == strapS3_reg) begin
      cfg_next = mab_cfg_t'(strapS3_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    strapS1_reg <= lowAddrIn;
    strapS2_reg <= strapS1_reg;
    strapS3_reg <= strapS2_reg;
    cfg_reg     <= cfg_next;
  end

  assign resetConfig = cfg_reg;
  assign lowAddrOe   = ~rst;

  // ****************************************************************
  // Transaction sequencer
  // ****************************************************************
  typedef enum {ST_IDLE, ST_ADDR, ST_HOLD, ST_TURN, ST_DATA, ST_DONE} mab_state_t;
  mab_state_t  state_reg, state_next;
  mab_req_t    cur_reg, cur_next;
  logic [3:0]  low_reg, low_next;
  logic [4:0]  left_reg, left_next;
  logic [1:0]  beat_reg, beat_next;
  logic [31:0] adOut_reg, adOut_next;
  logic        adOe_reg, adOe_next;
  logic        ale_reg, ale_next;
  logic        rel_reg, rel_next;
  logic        diag_reg, diag_next;
  logic [31:0] rword_reg, rword_next;
  logic        rvalid_reg, rvalid_next;
  logic        done_reg, done_next;
  logic [3:0]  strobes;

  always_comb begin
    strobes = ~lanesOf(req.addr[1:0], req.size, bigEndian);
    if (req.width != PW_32) begin
      strobes = STROBES_OFF;
    end
    if (!req.write && readStrobesOff) begin
      strobes = STROBES_OFF;
    end
  end

  always_comb begin
    state_next  = state_reg;
    cur_next    = cur_reg;
    low_next    = low_reg;
    left_next   = left_reg;
    beat_next   = beat_reg;
    adOut_next  = adOut_reg;
    adOe_next   = adOe_reg;
    ale_next    = ale_reg;
    rel_next    = rel_reg;
    diag_next   = diag_reg;
    rword_next  = rword_reg;
    rvalid_next = 1'b0;
    done_next   = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (reqValid) begin
          cur_next   = req;
          adOut_next = {req.addr[31:4], strobes};
          adOe_next  = 1'b1;
          ale_next   = 1'b1;
          rel_next   = 1'b0;
          diag_next  = req.cacheMiss;
          low_next   = req.burst ? 4'h0 : req.addr[3:0];
          left_next  = req.burst ? 5'(BURST_LEN) : 5'h01;
          beat_next  = 2'h0;
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        ale_next   = 1'b0;
        diag_next  = cur_reg.instrRef;
        if (cur_reg.burst == 1'b0 && cur_reg.width != PW_32) begin
          left_next = 5'((bytesOf(cur_reg.size) + stepOf(cur_reg.width) - 4'h1) / stepOf(cur_reg.width));
        end else if (cur_reg.burst) begin
          // A byte-wide burst needs sixteen beats, so the count is one bit wider than a nibble.
          left_next = 5'(BURST_LEN) * 5'(4'h4 / stepOf(cur_reg.width));
        end
        state_next = cfg_reg.extendedAddressHold ? ST_HOLD : ST_TURN;
      end
      ST_HOLD: begin
        state_next = ST_TURN;
      end
      ST_TURN: begin
        if (cur_reg.write) begin
          adOut_next = cur_reg.wdata;
        end else begin
          adOe_next = 1'b0;
          rel_next  = 1'b1;
        end
        state_next = ST_DATA;
      end
      ST_DATA: begin
        if (dataReady) begin
          if (!cur_reg.write) begin
            rword_next  = adIn;
            rvalid_next = 1'b1;
          end
          if (left_reg == 5'h01) begin
            adOe_next  = 1'b0;
            rel_next   = 1'b1;
            state_next = ST_DONE;
          end else begin
            low_next   = low_reg + stepOf(cur_reg.width);
            beat_next  = beat_reg + 2'h1;
            left_next  = left_reg - 5'h01;
          end
        end
      end
      ST_DONE: begin
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      cur_reg    <= '0;
      low_reg    <= 4'h0;
      left_reg   <= 5'h00;
      beat_reg   <= 2'h0;
      adOut_reg  <= 32'h0000_0000;
      adOe_reg   <= 1'b0;
      ale_reg    <= 1'b0;
      rel_reg    <= 1'b1;
      diag_reg   <= 1'b0;
      rword_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cur_reg    <= cur_next;
      low_reg    <= low_next;
      left_reg   <= left_next;
      beat_reg   <= beat_next;
      adOut_reg  <= adOut_next;
      adOe_reg   <= adOe_next;
      ale_reg    <= ale_next;
      rel_reg    <= rel_next;
      diag_reg   <= diag_next;
      rword_reg  <= rword_next;
      rvalid_reg <= rvalid_next;
      done_reg   <= done_next;
    end
  end

  // Reads collect into the burst buffer; the two-bit beat index wraps every four beats.
  mab_lane_reg #(.DEPTH(BURST_WORDS)) uReadBuf (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wrEn    (rvalid_next),
    .wrIdx   (beat_reg),
    .wrData  (adIn),
    .rdIdx   (readIdx),
    .rdData  (readBufData)
  );

  assign reqReady             = (state_reg == ST_IDLE) && !rst;
  assign adOut                = adOut_reg;
  assign adOe                 = adOe_reg;
  assign lowAddrOut           = low_reg;
  assign diag                 = diag_reg;
  assign addrLatchEnable      = ale_reg;
  assign drive_release_signal = rel_reg;
  assign readWord             = rword_reg;
  assign readWordValid        = rvalid_reg;
  assign done                 = done_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_ALE_ONE: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(addrLatchEnable) |=> !addrLatchEnable) else $error("Address strobe held too long.");
  AST_ALE_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
    addrLatchEnable |-> adOe && adOut[31:4] == cur_reg.addr[31:4]) else $error("Strobe without address.");
  AST_ALE_BEFORE: assert property (@(posedge sys_clk) disable iff (rst)
    addrLatchEnable |=> !addrLatchEnable ##1 !addrLatchEnable) else $error("Strobe overlaps data.");
  AST_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(drive_release_signal) |-> !adOe) else $error("Release while driving.");
  AST_WDATA: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_DATA && cur_reg.write |-> adOe && adOut == cur_reg.wdata) else $error("Bad write data.");
  AST_BURST_START: assert property (@(posedge sys_clk) disable iff (rst)
    addrLatchEnable && cur_reg.burst |-> lowAddrOut == 4'h0) else $error("Burst not from zero.");
  AST_DIAG_MISS: assert property (@(posedge sys_clk) disable iff (rst)
    addrLatchEnable && !cur_reg.write |-> diag == cur_reg.cacheMiss) else $error("Diag miss slot wrong.");
  AST_DIAG_REF: assert property (@(posedge sys_clk) disable iff (rst)
    addrLatchEnable && !cur_reg.write |=> diag == cur_reg.instrRef) else $error("Diag ref slot wrong.");
  AST_RSTROBE: assert property (@(posedge sys_clk) disable iff (rst)
    addrLatchEnable && !cur_reg.write && readStrobesOff |-> adOut[3:0] == STROBES_OFF)
    else $error("Read strobes active.");
  AST_STEP: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_DATA && dataReady && left_reg != 5'h01 |=> lowAddrOut == $past(low_reg) + stepOf(cur_reg.width))
    else $error("Low address step wrong.");

  COV_WRITE: cover property (@(posedge sys_clk) disable iff (rst) state_reg == ST_DATA && cur_reg.write && done_next);
  COV_BURST: cover property (@(posedge sys_clk) disable iff (rst) cur_reg.burst && done_next);
  COV_HOLD: cover property (@(posedge sys_clk) disable iff (rst) state_reg == ST_HOLD);
  COV_NARROW: cover property (@(posedge sys_clk) disable iff (rst) cur_reg.width == PW_8 && rvalid_next);
endmodule

// ---- mab_mem_model.sv ----
// Behavioural model of the external memory system that answers the bus engine.
`timescale 1ns/1ps
module mab_mem_model
  import mab_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        isWrite,
  input  wire logic        stall,
  input  wire logic [4:0]  beatLimit,
  input  wire logic [31:0] memWord,
  input  wire logic [3:0]  strap,
  input  wire logic        adOe,
  input  wire logic        drive_release_signal,
  input  wire logic        addrLatchEnable,
  input  wire logic        done,
  input  wire logic [3:0]  lowAddrOut,
  input  wire logic        lowAddrOe,
  output logic      [31:0] adIn,
  output logic      [3:0]  lowAddrIn,
  output logic             dataReady
);
  logic       active = 1'b0;
  logic [3:0] age = 4'h0;
  logic [4:0] beatsDone = 5'h00;
  logic       drives;

  initial adIn = 32'h0;
  initial dataReady = 1'b0;
  assign drives = active && !isWrite && drive_release_signal && !adOe;
  assign lowAddrIn = lowAddrOe ? lowAddrOut : strap;

  always @(posedge sys_clk) begin
    if (rst) begin
      active <= 1'b0;
    end else if (addrLatchEnable) begin
      active <= 1'b1;
      age <= 4'h0;
      beatsDone <= 5'h00;
    end else if (done) begin
      active <= 1'b0;
    end else begin
      age <= (age == 4'hF) ? age : age + 4'h1;
      beatsDone <= beatsDone + {4'h0, dataReady};
    end
  end

  // Released lines toggle so a stale value can never pass for data.
  always @(negedge sys_clk) begin
    dataReady <= active && age >= 4'h5 && beatsDone < beatLimit && !stall && (isWrite ? adOe : drives);
    adIn <= drives ? memWord : ~adIn;
  end
endmodule

// ---- mab_bus_if_test.sv ----
// Self-checking testbench for the multiplexed address/data bus engine.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errCount++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module mab_bus_if_test
  import mab_pkg::*;
();
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  mab_req_t    req = '0;
  mab_req_t    cur = '0;
  logic        reqValid = 1'b0;
  logic        reqReady, adOe, lowAddrOe, diag, addrLatchEnable, drive_release_signal;
  logic        bigEndian = 1'b0;
  logic        readStrobesOff = 1'b0;
  logic        dataReady, readWordValid, done;
  logic        stall = 1'b0;
  logic        prevAle = 1'b0;
  logic [31:0] adIn, adOut, readWord, readBufData, lastWord;
  logic [31:0] memWord = 32'h0;
  logic [31:0] expBuf [4];
  logic [3:0]  lowAddrIn, lowAddrOut, step;
  logic [3:0]  strap = 4'hA;
  logic [1:0]  readIdx = 2'h0;
  logic [4:0]  beatLimit = 5'h00;
  logic [4:0]  beatCnt = 5'h00;
  logic [4:0]  rwCnt = 5'h00;
  mab_cfg_t    resetConfig;
  integer      seed = 32'hc8d1;
  int          errCount = 0;
  int          checked = 0;
  int          cycles = 0;

  always #2 sys_clk = ~sys_clk;

  mab_bus_if mab_bus_if_i (.sys_clk(sys_clk), .rst(rst), .req(req), .reqValid(reqValid), .reqReady(reqReady),
    .bigEndian(bigEndian), .readStrobesOff(readStrobesOff), .dataReady(dataReady), .adIn(adIn), .adOut(adOut),
    .adOe(adOe), .lowAddrIn(lowAddrIn), .lowAddrOut(lowAddrOut), .lowAddrOe(lowAddrOe), .diag(diag),
    .addrLatchEnable(addrLatchEnable), .drive_release_signal(drive_release_signal), .resetConfig(resetConfig),
    .readWord(readWord), .readWordValid(readWordValid), .readIdx(readIdx), .readBufData(readBufData), .done(done));

  mab_mem_model mab_mem_model_i (.sys_clk(sys_clk), .rst(rst), .isWrite(cur.write), .stall(stall),
    .beatLimit(beatLimit), .memWord(memWord), .strap(strap), .adOe(adOe),
    .drive_release_signal(drive_release_signal), .addrLatchEnable(addrLatchEnable), .done(done),
    .lowAddrOut(lowAddrOut), .lowAddrOe(lowAddrOe), .adIn(adIn), .lowAddrIn(lowAddrIn), .dataReady(dataReady));

  // ****************************************************************
  // Expectations
  // ****************************************************************
  function automatic logic [3:0] expStrobe(mab_req_t r, logic be, logic off);
    logic [3:0] m;
    m = 4'(((5'h01 << (int'(r.size) + 1)) - 5'h01) << r.addr[1:0]);
    if (be) m = {m[0], m[1], m[2], m[3]};
    if (r.width != PW_32 || (off && !r.write)) return STROBES_OFF;
    return ~m;
  endfunction

  function automatic logic [3:0] stepOf(mab_width_t w);
    return (w == PW_32) ? 4'h4 : (w == PW_16) ? 4'h2 : 4'h1;
  endfunction

  function automatic logic [4:0] nBeats(mab_req_t r);
    if (r.burst) return 5'(16 / int'(stepOf(r.width)));
    if (r.width == PW_32) return 5'h01;
    return 5'((int'(r.size) + int'(stepOf(r.width))) / int'(stepOf(r.width)));
  endfunction

  // ****************************************************************
  // Bus monitor
  // ****************************************************************
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      wrapUp();
    end
    step = stepOf(cur.width);
    if (!rst) begin
      if (addrLatchEnable) begin
        `CHK({adOe, adOut[31:4]}, {1'b1, cur.addr[31:4]})
        `CHK(adOut[3:0], expStrobe(cur, bigEndian, readStrobesOff))
        if (!cur.write) `CHK(diag, cur.cacheMiss)
      end
      if (prevAle && !cur.write) `CHK(diag, cur.instrRef)
      if (addrLatchEnable || dataReady) begin
        `CHK(lowAddrOut & ~(step - 4'h1), ((cur.burst ? 4'h0 : cur.addr[3:0]) + 4'(beatCnt) * step) & ~(step - 4'h1))
      end
      if (dataReady) begin
        beatCnt <= beatCnt + 5'h01;
        lastWord <= memWord;
        expBuf[beatCnt[1:0]] <= memWord;
        `CHK(addrLatchEnable, 1'b0)
        if (!cur.write) `CHK({adOe, drive_release_signal}, 2'b01)
        if (cur.write && cur.width == PW_32 && cur.size == SZ_WORD) `CHK({adOe, adOut}, {1'b1, cur.wdata})
      end
      if (readWordValid) begin
        rwCnt <= rwCnt + 5'h01;
        `CHK(readWord, lastWord)
      end
    end
    prevAle <= addrLatchEnable;
    // The word changes on the rising edge so the model's drive and the recorded value agree.
    memWord <= $random(seed);
  end

  always @(negedge sys_clk) begin
    stall <= 1'($random(seed));
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  task automatic run(mab_req_t r);
    int n;
    @(negedge sys_clk);
    cur = r;
    req = r;
    reqValid = 1'b1;
    beatLimit = nBeats(r);
    beatCnt = 5'h00;
    rwCnt = 5'h00;
    bigEndian = 1'($random(seed));
    readStrobesOff = 1'($random(seed));
    while (reqReady !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    reqValid = 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++) @(negedge sys_clk);
    `CHK(done, 1'b1)
    `CHK(beatCnt, nBeats(r))
    `CHK(rwCnt, r.write ? 5'h00 : nBeats(r))
    if (r.burst && r.width == PW_32) begin
      for (n = 0; n < 4; n++) begin
        @(negedge sys_clk);
        readIdx = 2'(n);
        @(negedge sys_clk);
        `CHK(readBufData, expBuf[n])
      end
    end
  endtask

  task automatic wrapUp();
    if (errCount == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    mab_req_t r;
    for (int k = 0; k < 2; k++) begin
      @(negedge sys_clk);
      rst = 1'b1;
      strap = k ? 4'h5 : 4'hA;
      repeat (6) @(negedge sys_clk);
      `CHK({adOe, addrLatchEnable, drive_release_signal, lowAddrOe, reqReady}, 5'b00100)
      rst = 1'b0;
      @(negedge sys_clk);
      `CHK(4'(resetConfig), strap)
      `CHK({lowAddrOe, reqReady}, 2'b11)
      for (int i = 0; i < 45; i++) begin
        r = '0;
        r.addr = $random(seed);
        r.wdata = $random(seed);
        r.cacheMiss = 1'($random(seed));
        r.instrRef = 1'($random(seed));
        r.width = mab_width_t'(i % 3);
        r.size = mab_size_t'((i / 3) % 4);
        r.write = (i % 5 == 0) ? 1'b0 : 1'($random(seed));
        r.burst = (i % 5 == 0);
        if (r.burst) r.size = SZ_WORD;
        if (r.size == SZ_WORD) r.addr[1:0] = 2'h0;
        if (r.size == SZ_HALF) r.addr[0] = 1'b0;
        if (r.size == SZ_TRI) r.addr[1] = 1'b0;
        run(r);
      end
    end
    wrapUp();
  end
endmodule
